//--- rtl/cmd_decode_pkg.sv
package cmd_decode_pkg;

  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int A10_BIT = 10;
  localparam int A12_BIT = 12;
  localparam int BL_W = 4;
  localparam logic [BL_W-1:0] BURST_LEN_8 = 4'h8;
  localparam logic [BL_W-1:0] BURST_LEN_4 = 4'h4;
  localparam logic [1:0] MR_BL_FIXED8 = 2'h0;
  localparam logic [1:0] MR_BL_OTF = 2'h1;
  localparam logic [1:0] MR_BL_FIXED4 = 2'h2;
  localparam logic [BANK_W-1:0] MR0_SEL = 3'h0;
  localparam int WRITE_GUARD_CYCLES = 512;
  localparam int GUARD_W = 10;
  localparam int BURST_CYC_DIV = 2;

  typedef enum logic [4:0] {
    CMD_NONE = 5'h00,
    CMD_MODE_LOAD = 5'h01,
    CMD_REFRESH = 5'h02,
    CMD_SELF_REFRESH_ENTRY = 5'h03,
    CMD_SELF_REFRESH_EXIT = 5'h04,
    CMD_BANK_CLOSE = 5'h05,
    CMD_ALL_BANK_CLOSE = 5'h06,
    CMD_ROW_OPEN = 5'h07,
    CMD_WRITE = 5'h08,
    CMD_READ = 5'h09,
    CMD_NO_OPERATION = 5'h0a,
    CMD_IMPEDANCE_CAL_LONG = 5'h0b,
    CMD_IMPEDANCE_CAL_SHORT = 5'h0c,
    CMD_POWERDOWN_ENTRY = 5'h0d,
    CMD_POWERDOWN_EXIT = 5'h0e,
    CMD_ILLEGAL = 5'h1f
  } cmd_e;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_SELF_REFRESH = 2'h1,
    ST_POWER_DOWN = 2'h2
  } mode_e;

  typedef struct packed {
    logic              cs_b;
    logic              ras_b;
    logic              cas_b;
    logic              we_b;
    logic              cke;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_s;

  typedef struct packed {
    cmd_e              cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic              auto_close_select;
    logic              burst_chop_select;
    logic [BL_W-1:0]   burst_len;
  } cmd_out_s;

endpackage : cmd_decode_pkg

//--- rtl/ddr3_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_command_decoder
  import cmd_decode_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              cs_b,
  input  wire logic              ras_b,
  input  wire logic              cas_b,
  input  wire logic              we_b,
  input  wire logic              cke,
  input  wire logic [BANK_W-1:0] bank,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              on_die_termination,
  output logic                   cmd_valid,
  output cmd_out_s               cmd_out,
  output logic                   burst_busy,
  output logic                   self_refresh,
  output logic                   power_down,
  output logic                   termination_on,
  output logic                   write_blocked,
  output logic [1:0]             burst_mode
);

  cmd_pins_s   s1, s2;
  logic        cke_prev;
  mode_e       mode, next_mode;
  cmd_e        dec;
  logic [1:0]  next_burst_mode;
  logic [BL_W-1:0] next_len;
  logic        term_s1, term_s2;
  logic [BL_W-1:0] burst_cnt, next_burst_cnt;
  logic [GUARD_W-1:0] guard, next_guard;
  logic        idle_cmd;
  logic        next_cmd_valid;
  cmd_out_s    next_cmd_out;
  logic        sr_exit;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1      <= '0;
      s2      <= '0;
      term_s1 <= 1'b0;
      term_s2 <= 1'b0;
    end
    else
    begin
      s1 <= '{cs_b:cs_b, ras_b:ras_b, cas_b:cas_b, we_b:we_b, cke:cke, bank:bank, addr:addr};
      s2 <= s1;
      // Termination request is a pin as well, so it is synchronised too
      term_s1 <= on_die_termination;
      term_s2 <= term_s1;
    end
  end

  // Idle command is deselect or no-operation
  assign idle_cmd = s2.cs_b | (s2.ras_b & s2.cas_b & s2.we_b);
  // Self refresh exit condition for chk_selfref_exit only; the mode change itself waits for the command decode
  assign sr_exit  = (mode == ST_SELF_REFRESH) & s2.cke & idle_cmd;

  always_comb
  begin
    dec = CMD_ILLEGAL;
    if (!cke_prev)
    begin
      if (s2.cke && idle_cmd)
        dec = (mode == ST_SELF_REFRESH) ? CMD_SELF_REFRESH_EXIT : CMD_POWERDOWN_EXIT;
      else
        dec = CMD_NONE;
    end
    else if (!s2.cke)
    begin
      if (!s2.cs_b && !s2.ras_b && !s2.cas_b && s2.we_b)
        dec = CMD_SELF_REFRESH_ENTRY;
      else if (idle_cmd)
        dec = CMD_POWERDOWN_ENTRY;
    end
    else if (s2.cs_b)
      dec = CMD_NO_OPERATION;
    else
    begin
      case ({s2.ras_b, s2.cas_b, s2.we_b})
        3'h0: dec = CMD_MODE_LOAD;
        3'h1: dec = CMD_REFRESH;
        3'h2: dec = s2.addr[A10_BIT] ? CMD_ALL_BANK_CLOSE : CMD_BANK_CLOSE;
        3'h3: dec = CMD_ROW_OPEN;
        3'h4: dec = CMD_WRITE;
        3'h5: dec = CMD_READ;
        3'h6: dec = s2.addr[A10_BIT] ? CMD_IMPEDANCE_CAL_LONG : CMD_IMPEDANCE_CAL_SHORT;
        3'h7: dec = CMD_NO_OPERATION;
        default: dec = CMD_ILLEGAL;
      endcase
    end
  end

  always_comb
  begin
    next_mode       = mode;
    next_burst_mode = burst_mode;
    next_burst_cnt  = burst_cnt;
    next_guard      = guard;
    next_cmd_valid  = 1'b0;
    next_cmd_out    = cmd_out;
    if (burst_cnt != '0)
      next_burst_cnt = burst_cnt - 4'h1;
    if (guard != '0)
      next_guard = guard - 10'h1;
    if (s2.addr[A12_BIT])
      next_len = BURST_LEN_8;
    else
      next_len = BURST_LEN_4;
    if (burst_mode != MR_BL_OTF)
      next_len = (burst_mode == MR_BL_FIXED4) ? BURST_LEN_4 : BURST_LEN_8;
    case (dec)
      CMD_MODE_LOAD:
      begin
        if (s2.bank == MR0_SEL)
          next_burst_mode = s2.addr[1:0];
      end
      CMD_SELF_REFRESH_ENTRY: next_mode = ST_SELF_REFRESH;
      CMD_POWERDOWN_ENTRY: next_mode = ST_POWER_DOWN;
      CMD_POWERDOWN_EXIT: next_mode = ST_ACTIVE;
      CMD_SELF_REFRESH_EXIT:
      begin
        next_mode  = ST_ACTIVE;
        next_guard = GUARD_W'(WRITE_GUARD_CYCLES - 1);
      end
      CMD_READ, CMD_WRITE:
      begin
        if (burst_cnt == '0)
          next_burst_cnt = BL_W'(next_len / BL_W'(BURST_CYC_DIV));
      end
      default: next_mode = mode;
    endcase
    if (dec != CMD_NONE && dec != CMD_NO_OPERATION && dec != CMD_ILLEGAL)
    begin
      next_cmd_valid                 = 1'b1;
      next_cmd_out.cmd               = dec;
      next_cmd_out.bank              = s2.bank;
      next_cmd_out.addr              = s2.addr;
      next_cmd_out.auto_close_select = s2.addr[A10_BIT];
      next_cmd_out.burst_chop_select = (burst_mode == MR_BL_OTF) & ~s2.addr[A12_BIT];
      next_cmd_out.burst_len         = next_len;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cke_prev       <= 1'b0;
      mode           <= ST_ACTIVE;
      burst_mode     <= MR_BL_FIXED8;
      burst_cnt      <= '0;
      guard          <= '0;
      cmd_valid      <= 1'b0;
      cmd_out        <= '0;
      burst_busy     <= 1'b0;
      self_refresh   <= 1'b0;
      power_down     <= 1'b0;
      termination_on <= 1'b0;
      write_blocked  <= 1'b0;
    end
    else
    begin
      cke_prev       <= s2.cke;
      mode           <= next_mode;
      burst_mode     <= next_burst_mode;
      burst_cnt      <= next_burst_cnt;
      guard          <= next_guard;
      cmd_valid      <= next_cmd_valid;
      cmd_out        <= next_cmd_out;
      burst_busy     <= (next_burst_cnt != '0);
      self_refresh   <= (next_mode == ST_SELF_REFRESH);
      power_down     <= (next_mode == ST_POWER_DOWN);
      termination_on <= term_s2 & (next_mode != ST_SELF_REFRESH);
      write_blocked  <= (next_guard != '0);
    end
  end

  chk_precharge_all: assert property (@(posedge clock) disable iff (!rst_b)
    (cke_prev && s2.cke && !s2.cs_b && !s2.ras_b && s2.cas_b && !s2.we_b && s2.addr[A10_BIT])
    |=> (cmd_valid && cmd_out.cmd == CMD_ALL_BANK_CLOSE))
    else $error("all bank close not decoded");

  chk_deselect_idle: assert property (@(posedge clock) disable iff (!rst_b)
    (cke_prev && s2.cke && s2.cs_b) |=> !cmd_valid)
    else $error("deselect produced a command");

  chk_selfref_entry: assert property (@(posedge clock) disable iff (!rst_b)
    (cke_prev && !s2.cke && !s2.cs_b && !s2.ras_b && !s2.cas_b && s2.we_b) |=> self_refresh)
    else $error("self refresh not entered");

  chk_selfref_exit: assert property (@(posedge clock) disable iff (!rst_b)
    sr_exit && !cke_prev |=> (!self_refresh && write_blocked))
    else $error("self refresh exit missed");

  chk_term_off: assert property (@(posedge clock) disable iff (!rst_b)
    self_refresh |-> !termination_on)
    else $error("termination on in self refresh");

  chk_fixed_len: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_valid && (cmd_out.cmd == CMD_READ || cmd_out.cmd == CMD_WRITE)
      && $past(burst_mode) == MR_BL_FIXED8)
    |-> cmd_out.burst_len == BURST_LEN_8)
    else $error("fixed length not honoured");

  chk_burst_runs: assert property (@(posedge clock) disable iff (!rst_b)
    (burst_busy && burst_cnt > 4'h1) |=> burst_busy)
    else $error("burst cut short");

  chk_auto_close: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_valid && (cmd_out.cmd == CMD_WRITE || cmd_out.cmd == CMD_READ))
    |-> cmd_out.auto_close_select == cmd_out.addr[A10_BIT])
    else $error("auto close flag wrong");

  chk_pd_entry: assert property (@(posedge clock) disable iff (!rst_b)
    (mode == ST_ACTIVE && cke_prev && !s2.cke && idle_cmd) |=> power_down)
    else $error("power-down not entered");

endmodule : ddr3_command_decoder
`default_nettype wire

//--- testbench/ddr3_command_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_command_decoder_bench;
  import cmd_decode_pkg::*;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic       req_valid = 1'b0;
  logic       term_req = 1'b0;
  cmd_pins_s  req = '{cs_b: 1'b0, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, default: '0};
  cmd_pins_s  pins;
  cmd_out_s   cmd_out;
  logic [1:0] burst_mode;
  logic       cmd_valid, burst_busy, self_refresh, power_down, termination_on, write_blocked;
  logic [15:0] a;
  int         num_errors = 0;
  int         num_checks = 0;
  int         cycles = 0;
  cmd_e       ce [6] = '{CMD_ROW_OPEN, CMD_BANK_CLOSE, CMD_ALL_BANK_CLOSE, CMD_REFRESH,
                         CMD_IMPEDANCE_CAL_LONG, CMD_IMPEDANCE_CAL_SHORT};
  logic [3:0] strobes [6] = '{4'h3, 4'h2, 4'h2, 4'h1, 4'h6, 4'h6};

  ddr3_ctrl_model u_ddr3_ctrl_model (.req_valid(req_valid), .req(req), .pins(pins));
  ddr3_command_decoder u_ddr3_command_decoder (
    .clock(clock), .rst_b(rst_b), .cs_b(pins.cs_b), .ras_b(pins.ras_b), .cas_b(pins.cas_b),
    .we_b(pins.we_b), .cke(pins.cke), .bank(pins.bank), .addr(pins.addr),
    .on_die_termination(term_req), .cmd_valid(cmd_valid), .cmd_out(cmd_out),
    .burst_busy(burst_busy), .self_refresh(self_refresh), .power_down(power_down),
    .termination_on(termination_on), .write_blocked(write_blocked), .burst_mode(burst_mode));

  always #25 clock = ~clock;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %0t %s", $time, what);
    end
  endtask : chk_val

  task automatic chk_cmd(input cmd_e c);
    num_checks++;
    if (cmd_valid !== 1'b1 || cmd_out.cmd !== c)
    begin
      num_errors++;
      $display("mismatch %0t command %0h", $time, c);
    end
  endtask : chk_cmd

  // One command cycle, then idle; returns where the decode result is settled
  task automatic send(input logic [3:0] s, input logic k, input logic [2:0] b,
                      input logic [15:0] ad);
    @(posedge clock);
    {req.cs_b, req.ras_b, req.cas_b, req.we_b} <= s;
    req.cke <= k;
    req.bank <= b;
    req.addr <= ad;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : send

  task automatic burst(input int len);
    chk_val(burst_busy, 1'b1, "busy start");
    repeat (len / BURST_CYC_DIV - 1) @(posedge clock);
    #1;
    chk_val(burst_busy, 1'b1, "busy held");
    @(posedge clock);
    #1;
    chk_val(burst_busy, 1'b0, "busy end");
  endtask : burst

  initial
  begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    send(4'h7, 1'b1, 3'h0, 16'h0000);
    chk_cmd(CMD_POWERDOWN_EXIT);
    send(4'h0, 1'b1, MR0_SEL, 16'h0001);
    chk_cmd(CMD_MODE_LOAD);
    chk_val(burst_mode, MR_BL_OTF, "mode");
    send(4'h0, 1'b1, 3'h1, 16'h0002);
    chk_cmd(CMD_MODE_LOAD);
    chk_val(burst_mode, MR_BL_OTF, "other register");
    for (int i = 0; i < 8; i++)
    begin
      a = 16'h0048;
      a[A10_BIT] = i[0];
      a[A12_BIT] = i[1];
      send(i[2] ? 4'h5 : 4'h4, 1'b1, 3'h5, a);
      chk_cmd(i[2] ? CMD_READ : CMD_WRITE);
      chk_val(cmd_out.addr, a, "address");
      chk_val(cmd_out.auto_close_select, i[0], "auto close");
      chk_val(cmd_out.burst_chop_select, !i[1], "chop");
      chk_val(cmd_out.burst_len, i[1] ? BURST_LEN_8 : BURST_LEN_4, "length");
      burst(i[1] ? 8 : 4);
    end
    $display("read write test done");
    send(4'h0, 1'b1, MR0_SEL, {14'h0, MR_BL_FIXED4});
    send(4'h5, 1'b1, 3'h1, 16'h1000);
    chk_val(cmd_out.burst_len, BURST_LEN_4, "fixed4");
    burst(4);
    send(4'h0, 1'b1, MR0_SEL, {14'h0, MR_BL_FIXED8});
    send(4'h4, 1'b1, 3'h1, 16'h0000);
    chk_val(cmd_out.burst_len, BURST_LEN_8, "fixed8");
    burst(8);
    $display("fixed length test done");
    for (int i = 0; i < 6; i++)
    begin
      a = 16'h0123;
      a[A10_BIT] = (i == 2 || i == 4);
      send(strobes[i], 1'b1, 3'h6, a);
      chk_cmd(ce[i]);
      chk_val(cmd_out.bank, 3'h6, "bank");
    end
    send(4'h7, 1'b1, 3'h2, 16'h0000);
    chk_val(cmd_valid, 1'b0, "nop");
    send(4'hf, 1'b1, 3'h2, 16'h0000);
    chk_val(cmd_valid, 1'b0, "deselect");
    chk_val(cmd_out.cmd, CMD_IMPEDANCE_CAL_SHORT, "held");
    $display("command table test done");
    @(posedge clock);
    term_req <= 1'b1;
    send(4'h7, 1'b1, 3'h0, 16'h0000);
    chk_val(termination_on, 1'b1, "term on");
    send(4'h1, 1'b0, 3'h0, 16'h0000);
    chk_cmd(CMD_SELF_REFRESH_ENTRY);
    chk_val({self_refresh, termination_on}, 2'h2, "in self refresh");
    send(4'h7, 1'b1, 3'h0, 16'h0000);
    chk_cmd(CMD_SELF_REFRESH_EXIT);
    chk_val({self_refresh, write_blocked}, 2'h1, "exit");
    repeat (WRITE_GUARD_CYCLES - 2) @(posedge clock);
    #1;
    chk_val(write_blocked, 1'b1, "guard held");
    @(posedge clock);
    #1;
    chk_val({write_blocked, termination_on}, 2'h1, "guard end");
    $display("self refresh test done");
    send(4'h7, 1'b0, 3'h0, 16'h0000);
    chk_cmd(CMD_POWERDOWN_ENTRY);
    chk_val(power_down, 1'b1, "powered down");
    send(4'h1, 1'b0, 3'h0, 16'h0000);
    chk_val({cmd_valid, power_down}, 2'h1, "no refresh");
    send(4'hf, 1'b1, 3'h0, 16'h0000);
    chk_cmd(CMD_POWERDOWN_EXIT);
    chk_val(power_down, 1'b0, "awake");
    $display("power down test done");
    wrap_up();
  end
endmodule : ddr3_command_decoder_bench
`default_nettype wire

//--- testbench/ddr3_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_ctrl_model
  import cmd_decode_pkg::*;
(
  input  wire logic      req_valid,
  input  wire cmd_pins_s req,
  output cmd_pins_s      pins
);
  // Idle cycles carry no-operation; address lines carry the inverse of the held request address
  always_comb
  begin
    pins = req;
    if (!req_valid)
    begin
      pins.cs_b  = 1'b0;
      pins.ras_b = 1'b1;
      pins.cas_b = 1'b1;
      pins.we_b  = 1'b1;
      pins.addr  = ~req.addr;
    end
  end
endmodule : ddr3_ctrl_model
`default_nettype wire
